//--- common/acsr_defines.vh
// register offsets, field positions and reset values of the channel status/control bank
`ifndef ACSR_DEFINES_VH
`define ACSR_DEFINES_VH
`define ACSR_OFS_OUT_STATE 8'h05
`define ACSR_OFS_PLAY_MUTE 8'h06
`define ACSR_OFS_FOLD_DIAG 8'h07
`define ACSR_OFS_GAIN 8'h08
`define ACSR_OFS_OC_FOLD 8'h09
`define ACSR_OFS_SW_CFG 8'h0a
`define ACSR_RST_GAIN 8'haa
`define ACSR_RST_OC_FOLD 8'hf0
`define ACSR_RST_SW_CFG 8'h0d
`define ACSR_RST_OUT_STATE 8'h0f
`define ACSR_RST_PLAY_MUTE 8'h00
`define ACSR_RST_FOLD_DIAG 8'h00
`define ACSR_RST_LIMIT 4'hf
`define ACSR_RST_RD_DATA 8'h00
`define ACSR_OC_WR_MASK 8'hf1
`define ACSR_NUM_CHAN 4
`define ACSR_FLOAT_LSB 0
`define ACSR_LL_LSB 4
`define ACSR_PLAY_LSB 0
`define ACSR_MUTE_LSB 4
`define ACSR_DIAG_LSB 0
`define ACSR_FOLD_LSB 4
`define ACSR_FOLD_DIS_BIT 0
`define ACSR_LIMIT_MSB 7
`define ACSR_LIMIT_LSB 4
`define ACSR_RATE_MSB 1
`define ACSR_RATE_LSB 0
`define ACSR_PIN_MSB 3
`define ACSR_PIN_LSB 2
`define ACSR_HARD_STOP_BIT 4
`define ACSR_PHASE_BIT 5
`define ACSR_SYNC_BIT 6
`define ACSR_PIN_FOLD_BIT 7
`define ACSR_GAIN_12DB 2'h0
`define ACSR_GAIN_20DB 2'h1
`define ACSR_GAIN_26DB 2'h2
`define ACSR_GAIN_32DB 2'h3
`define ACSR_RATE_500K 2'h0
`define ACSR_RATE_417K 2'h1
`define ACSR_RATE_357K 2'h2
`define ACSR_RATE_BAD 2'h3
`define ACSR_PIN_TWEETER 2'h0
`define ACSR_PIN_CLIP 2'h1
`define ACSR_PIN_OTW 2'h2
`define ACSR_PIN_NO_FOLD 2'h3
`endif

//--- src/acsr_regs.v
// status and control register bank for the four amplifier channels
`timescale 1ns/100ps
`include "acsr_defines.vh"

// Summary of operation
// RL1: low-low flag set only when both outputs grounded
// RL2: float flags in 0x05 bits 3-0, reset one
// RL3: mute flags in 0x06 bits 7-4
// RL4: play flags in 0x06 bits 3-0
// RL5: thermal fold flags in 0x07 bits 7-4
// RL6: load-check flags in 0x07 bits 3-0
// RL7: gain codes 12/20/26/32 dB, reset 26 dB
// RL8: gain fields packed channel 4 high, channel 1 low
// RL9: current limit select bits 7-4, reset 0xf
// RL10: config register fields for rate and flag pin
// RL11: rate codes 500/417/357 kHz, 11 decodes as 417 kHz and sets the invalid flag
// RL12: flag pin select codes, reset no fold report
// RL13: writes to status registers are ignored
// RL14: fold disable bit forces fold flags to zero
module acsr_regs (
    input wire clk,
    input wire sys_rst,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] addr,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data_r,
    input wire [3:0] chan_pos_grounded,
    input wire [3:0] chan_neg_grounded,
    input wire [3:0] chan_float,
    input wire [3:0] chan_silenced,
    input wire [3:0] chan_playing,
    input wire [3:0] chan_thermal_fold,
    input wire [3:0] chan_load_check,
    output reg [7:0] chan_gain_sel_r,
    output reg [3:0] chan_current_limit_sel_r,
    output reg thermal_fold_disable_r,
    output reg [1:0] switching_rate_sel_r,
    output reg [1:0] flag_pin_select_r,
    output reg hard_stop_en_r,
    output reg phase_offset_en_r,
    output reg sync_pulse_r,
    output reg flag_pin_fold_report_r,
    output reg [1:0] switching_rate_code_r,
    output reg rate_sel_invalid_r
);

    // storage of the read-only status bytes
    reg [7:0] out_state_r;
    reg [7:0] play_mute_r;
    reg [7:0] fold_diag_r;

    // storage of the writable control bytes
    reg [7:0] gain_r;
    reg [7:0] oc_fold_r;
    reg [7:0] sw_cfg_r;

    // next values
    wire [7:0] out_state_nxt;
    wire [7:0] play_mute_nxt;
    wire [7:0] fold_diag_nxt;
    reg [7:0] gain_nxt;
    reg [7:0] oc_fold_nxt;
    reg [7:0] sw_cfg_nxt;
    reg [7:0] rd_nxt;
    reg [1:0] rate_code_nxt;
    reg rate_invalid_nxt;

    // write decode; the status offsets get no strobe at all [RL13]
    wire wr_gain;
    wire wr_oc_fold;
    wire wr_sw_cfg;
    wire fold_enabled;
    wire [1:0] rate_field;

    assign wr_gain = wr_en & (addr == `ACSR_OFS_GAIN);
    assign wr_oc_fold = wr_en & (addr == `ACSR_OFS_OC_FOLD);
    assign wr_sw_cfg = wr_en & (addr == `ACSR_OFS_SW_CFG);
    assign fold_enabled = ~oc_fold_r[`ACSR_FOLD_DIS_BIT];
    assign rate_field = sw_cfg_r[`ACSR_RATE_MSB:`ACSR_RATE_LSB];

    // one slice of status per channel, bit 0 of each field is channel 1
    genvar ch;
    generate
        for (ch = 0; ch < `ACSR_NUM_CHAN; ch = ch + 1) begin : g_chan
            // one grounded side alone is not low-low
            assign out_state_nxt[`ACSR_LL_LSB + ch] =
                chan_pos_grounded[ch] & chan_neg_grounded[ch]; // [RL1]
            assign out_state_nxt[`ACSR_FLOAT_LSB + ch] = chan_float[ch]; // [RL2]
            assign play_mute_nxt[`ACSR_MUTE_LSB + ch] = chan_silenced[ch]; // [RL3]
            assign play_mute_nxt[`ACSR_PLAY_LSB + ch] = chan_playing[ch]; // [RL4]
            // suppressed while disabled, so a stale fold flag cannot linger
            assign fold_diag_nxt[`ACSR_FOLD_LSB + ch] =
                chan_thermal_fold[ch] & fold_enabled; // [RL5] [RL14]
            assign fold_diag_nxt[`ACSR_DIAG_LSB + ch] = chan_load_check[ch]; // [RL6]
        end
    endgenerate

    // status bytes follow the live channel state with one cycle of lag [RL13]
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_state_r <= `ACSR_RST_OUT_STATE; // [RL1] [RL2]
        end else begin
            out_state_r <= out_state_nxt;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            play_mute_r <= `ACSR_RST_PLAY_MUTE; // [RL3] [RL4]
        end else begin
            play_mute_r <= play_mute_nxt;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fold_diag_r <= `ACSR_RST_FOLD_DIAG; // [RL5] [RL6]
        end else begin
            fold_diag_r <= fold_diag_nxt;
        end
    end

    always @* begin
        gain_nxt = gain_r;
        oc_fold_nxt = oc_fold_r;
        sw_cfg_nxt = sw_cfg_r;
        if (wr_gain) begin
            gain_nxt = wr_data; // [RL8]
        end
        if (wr_oc_fold) begin
            // reserved bits 3-1 are held at zero [RL14]
            oc_fold_nxt = wr_data & `ACSR_OC_WR_MASK; // [RL9]
        end
        if (wr_sw_cfg) begin
            // a forbidden rate code is kept as written and only caught at decode
            sw_cfg_nxt = wr_data; // [RL10]
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gain_r <= `ACSR_RST_GAIN; // [RL7]
        end else begin
            gain_r <= gain_nxt;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oc_fold_r <= `ACSR_RST_OC_FOLD; // [RL9]
        end else begin
            oc_fold_r <= oc_fold_nxt;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sw_cfg_r <= `ACSR_RST_SW_CFG; // [RL10] [RL11] [RL12]
        end else begin
            sw_cfg_r <= sw_cfg_nxt;
        end
    end

    always @* begin
        case (addr)
            `ACSR_OFS_OUT_STATE: rd_nxt = out_state_r;
            `ACSR_OFS_PLAY_MUTE: rd_nxt = play_mute_r;
            `ACSR_OFS_FOLD_DIAG: rd_nxt = fold_diag_r;
            `ACSR_OFS_GAIN: rd_nxt = gain_r;
            `ACSR_OFS_OC_FOLD: rd_nxt = oc_fold_r;
            `ACSR_OFS_SW_CFG: rd_nxt = sw_cfg_r;
            default: rd_nxt = 8'h00;
        endcase
    end

    // read data holds between reads; a read in a write cycle sees the old byte
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_r <= `ACSR_RST_RD_DATA;
        end else if (rd_en) begin
            rd_data_r <= rd_nxt;
        end
    end

    // control outputs are registered copies, one cycle behind the storage
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            chan_gain_sel_r <= `ACSR_RST_GAIN; // [RL7]
            chan_current_limit_sel_r <= `ACSR_RST_LIMIT; // [RL9]
            thermal_fold_disable_r <= 1'b0;
        end else begin
            chan_gain_sel_r <= gain_r; // [RL7] [RL8]
            chan_current_limit_sel_r <= oc_fold_r[`ACSR_LIMIT_MSB:`ACSR_LIMIT_LSB]; // [RL9]
            thermal_fold_disable_r <= oc_fold_r[`ACSR_FOLD_DIS_BIT]; // [RL14]
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            switching_rate_sel_r <= `ACSR_RATE_417K; // [RL11]
            flag_pin_select_r <= `ACSR_PIN_NO_FOLD; // [RL12]
            hard_stop_en_r <= 1'b0;
            phase_offset_en_r <= 1'b0;
            sync_pulse_r <= 1'b0;
            flag_pin_fold_report_r <= 1'b0;
        end else begin
            switching_rate_sel_r <= rate_field; // [RL10]
            flag_pin_select_r <= sw_cfg_r[`ACSR_PIN_MSB:`ACSR_PIN_LSB]; // [RL12]
            hard_stop_en_r <= sw_cfg_r[`ACSR_HARD_STOP_BIT];
            phase_offset_en_r <= sw_cfg_r[`ACSR_PHASE_BIT];
            sync_pulse_r <= sw_cfg_r[`ACSR_SYNC_BIT];
            flag_pin_fold_report_r <= sw_cfg_r[`ACSR_PIN_FOLD_BIT];
        end
    end

    // the forbidden rate code falls back to the default so the modulator stays sane
    always @* begin
        rate_code_nxt = rate_field;
        rate_invalid_nxt = 1'b0;
        if (rate_field == `ACSR_RATE_BAD) begin
            rate_code_nxt = `ACSR_RATE_417K; // [RL11]
            rate_invalid_nxt = 1'b1;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            switching_rate_code_r <= `ACSR_RATE_417K; // [RL11]
            rate_sel_invalid_r <= 1'b0;
        end else begin
            switching_rate_code_r <= rate_code_nxt;
            rate_sel_invalid_r <= rate_invalid_nxt;
        end
    end

endmodule

//--- bench/acsr_host.sv
// host model: bench requests become one-cycle bus strobes
`timescale 1ns/100ps
module acsr_host(input wire clk, go, wr, input wire [7:0] a, d,
    output logic wr_en = 0, rd_en = 0, output logic [7:0] addr = 0, wr_data = 0);
    always @(posedge clk) begin
        wr_en <= go & wr;
        rd_en <= go & ~wr;
        addr <= a;
        wr_data <= d;
    end
endmodule

//--- bench/acsr_regs_sva.sv
// assertions on the channel register bank ports
`timescale 1ns/100ps
module acsr_chk(input wire clk, sys_rst, wr_en, rd_en, thermal_fold_disable_r,
    rate_sel_invalid_r, input wire [7:0] addr, wr_data, rd_data_r, chan_gain_sel_r,
    input wire [3:0] chan_pos_grounded, chan_neg_grounded, chan_float, chan_silenced,
    chan_playing, chan_load_check, chan_current_limit_sel_r,
    input wire [1:0] switching_rate_sel_r, switching_rate_code_r);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire [3:0] ll = chan_pos_grounded & chan_neg_grounded;
    wire [7:0] oc = {chan_current_limit_sel_r, 3'h0, thermal_fold_disable_r};
    wire [1:0] rs = switching_rate_sel_r;
    wire fd = thermal_fold_disable_r;
    wire r7 = rd_en && addr == 8'h07;
    property p_s5; rd_en && addr == 8'h05 |=> rd_data_r == {$past(ll, 2), $past(chan_float, 2)};
    endproperty
    a_s5: assert property (p_s5) else $error("bad 05");
    property p_s6; rd_en && addr == 8'h06 |=> rd_data_r[7:4] == $past(chan_silenced, 2) &&
        rd_data_r[3:0] == $past(chan_playing, 2); endproperty
    a_s6: assert property (p_s6) else $error("bad 06");
    property p_ld; r7 |=> rd_data_r[3:0] == $past(chan_load_check, 2); endproperty
    a_ld: assert property (p_ld) else $error("bad 07");
    property p_fd; r7 && fd && $past(fd) |=> rd_data_r[7:4] == 4'h0; endproperty
    a_fd: assert property (p_fd) else $error("fold shown");
    property p_gn; wr_en && addr == 8'h08 |=> ##1 chan_gain_sel_r == $past(wr_data, 2); endproperty
    a_gn: assert property (p_gn) else $error("bad gain");
    property p_oc; wr_en && addr == 8'h09 |=> ##1 oc == ($past(wr_data, 2) & 8'hf1); endproperty
    a_oc: assert property (p_oc) else $error("bad limit");
    property p_rt; switching_rate_code_r == (rs == 2'h3 ? 2'h1 : rs) &&
        rate_sel_invalid_r == (rs == 2'h3); endproperty
    a_rt: assert property (p_rt) else $error("bad rate");
    property p_rs; $fell(sys_rst) |-> chan_gain_sel_r == 8'haa && oc == 8'hf0 &&
        switching_rate_code_r == 2'h1; endproperty
    a_rs: assert property (p_rs) else $error("bad reset");
    c_rd: cover property (rd_en && addr == 8'h05);
    c_wr: cover property (wr_en && addr == 8'h08);
    c_fd: cover property (r7 && fd);
endmodule
bind acsr_regs acsr_chk i_acsr_chk (
    .clk(clk), .sys_rst(sys_rst), .wr_en(wr_en), .rd_en(rd_en),
    .thermal_fold_disable_r(thermal_fold_disable_r), .rate_sel_invalid_r(rate_sel_invalid_r),
    .addr(addr), .wr_data(wr_data), .rd_data_r(rd_data_r), .chan_gain_sel_r(chan_gain_sel_r),
    .chan_pos_grounded(chan_pos_grounded), .chan_neg_grounded(chan_neg_grounded),
    .chan_float(chan_float), .chan_silenced(chan_silenced), .chan_playing(chan_playing),
    .chan_load_check(chan_load_check), .chan_current_limit_sel_r(chan_current_limit_sel_r),
    .switching_rate_sel_r(switching_rate_sel_r),
    .switching_rate_code_r(switching_rate_code_r)
);

//--- bench/tb_acsr_regs.sv
// self-checking bench for the channel register bank
`timescale 1ns/100ps
module tb_acsr_regs;
    logic clk = 0, sys_rst = 1, go = 0, wr = 0;
    logic [7:0] a = 0, d = 0, g = 8'haa, o = 8'hf0, c = 8'h0d;
    logic [31:0] chs = 0;
    integer seed = 18, fail_count = 0, tests_run = 0, i, ra, rv;
    wire wr_en, rd_en, thermal_fold_disable_r, hard_stop_en_r, phase_offset_en_r, sync_pulse_r;
    wire flag_pin_fold_report_r, rate_sel_invalid_r;
    wire [7:0] addr, wr_data, rd_data_r, chan_gain_sel_r;
    wire [3:0] chan_pos_grounded, chan_neg_grounded, chan_float, chan_silenced, chan_playing;
    wire [3:0] chan_thermal_fold, chan_load_check, chan_current_limit_sel_r;
    wire [1:0] switching_rate_sel_r, flag_pin_select_r, switching_rate_code_r;
    assign {chan_pos_grounded, chan_neg_grounded, chan_float, chan_silenced, chan_playing,
        chan_thermal_fold, chan_load_check} = chs[27:0];
    always #20 clk = ~clk;
    acsr_regs i_acsr_regs (
        .clk(clk), .sys_rst(sys_rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .rd_data_r(rd_data_r),
        .chan_pos_grounded(chan_pos_grounded), .chan_neg_grounded(chan_neg_grounded),
        .chan_float(chan_float), .chan_silenced(chan_silenced), .chan_playing(chan_playing),
        .chan_thermal_fold(chan_thermal_fold), .chan_load_check(chan_load_check),
        .chan_gain_sel_r(chan_gain_sel_r), .chan_current_limit_sel_r(chan_current_limit_sel_r),
        .thermal_fold_disable_r(thermal_fold_disable_r),
        .switching_rate_sel_r(switching_rate_sel_r), .flag_pin_select_r(flag_pin_select_r),
        .hard_stop_en_r(hard_stop_en_r), .phase_offset_en_r(phase_offset_en_r),
        .sync_pulse_r(sync_pulse_r), .flag_pin_fold_report_r(flag_pin_fold_report_r),
        .switching_rate_code_r(switching_rate_code_r), .rate_sel_invalid_r(rate_sel_invalid_r)
    );
    acsr_host i_acsr_host (
        .clk(clk), .go(go), .wr(wr), .a(a), .d(d),
        .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data)
    );
    // fold flags read as zero while the disable bit is stored
    function [7:0] ex(input integer ad);
        case (ad)
            5: ex = {chs[27:24] & chs[23:20], chs[19:16]};
            6: ex = chs[15:8];
            7: ex = {chs[7:4] & ~{4{o[0]}}, chs[3:0]};
            8: ex = g;
            9: ex = o;
            10: ex = c;
            default: ex = 8'h00;
        endcase
    endfunction
    task chk(input [31:0] s, e);
        tests_run = tests_run + 1;
        if (s !== e) begin
            fail_count = fail_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task acc(input w, input [7:0] ad, dd);
        @(posedge clk);
        go <= 1;
        wr <= w;
        a <= ad;
        d <= dd;
        @(posedge clk);
        go <= 0;
        @(posedge clk);
        #1;
    endtask
    task step(input w, input integer ad, dd);
        if (w) acc(1, ad[7:0], dd[7:0]);
        if (w && ad == 8) g = dd[7:0];
        if (w && ad == 9) o = dd[7:0] & 8'hf1;
        if (w && ad == 10) c = dd[7:0];
        acc(0, ad[7:0], 8'h00);
        chk({24'h0, rd_data_r}, {24'h0, ex(ad)});
        chk({24'h0, flag_pin_fold_report_r, sync_pulse_r, phase_offset_en_r, hard_stop_en_r,
            flag_pin_select_r, switching_rate_code_r}, {24'h0, c});
        chk({24'h0, chan_gain_sel_r}, {24'h0, g});
        chk({24'h0, chan_current_limit_sel_r, 3'h0, thermal_fold_disable_r},
            {24'h0, o});
        chk({30'h0, switching_rate_sel_r}, {30'h0, c[1:0]});
        chk({31'h0, rate_sel_invalid_r}, {31'h0, c[1:0] == 2'h3});
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 0;
        for (i = 5; i < 12; i = i + 1) step(0, i, 0);
        @(posedge clk) chs <= 32'hffffffff;
        step(1, 9, 255);
        step(0, 7, 0);
        for (i = 0; i < 80; i = i + 1) begin
            @(posedge clk) chs <= $random(seed);
            ra = $unsigned($random(seed)) % 7 + 5;
            rv = $random(seed);
            // software never asks for the undefined rate code
            if (ra == 10 && rv[1:0] == 2'h3) rv[0] = 1'b0;
            step(1, ra, rv);
        end
        finish_test;
    end
endmodule
